//--- dv/rcr_host_model.sv
/* Serial bus host model that reads and writes the register slice.
   Assumes the bench resolves the open-drain data line with a pull-up. */
module rcr_host_model #(
    parameter logic [6:0] ADDR = 7'h50
) (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // four clocks per bus level, above the three the target needs
    task automatic hp();
        repeat (4) @(negedge clk_in);
    endtask
    task automatic start();
        sda_oe_out = 1'b0;
        hp();
        scl_out = 1'b1;
        hp();
        sda_oe_out = 1'b1;
        hp();
        scl_out = 1'b0;
        hp();
    endtask
    task automatic stop();
        sda_oe_out = 1'b1;
        hp();
        scl_out = 1'b1;
        hp();
        sda_oe_out = 1'b0;
        hp();
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_oe_out = !b;
        hp();
        scl_out = 1'b1;
        hp();
        r = sda_in;
        scl_out = 1'b0;
        hp();
    endtask
    // msb first, ninth bit released for the acknowledge
    task automatic xb(input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // pointer byte, then data or repeated start and one read byte
    task automatic xfer(input logic rnw, input logic [7:0] p,
                        input logic [7:0] wd, output logic [7:0] rd,
                        output logic ok);
        logic a0, a1, a2, an;
        logic [7:0] q;
        start();
        xb({ADDR, 1'b0}, q, a0);
        xb(p, q, a1);
        if (rnw) begin
            start();
            xb({ADDR, 1'b1}, q, a2);
            // own NACK on the read byte; keep the address acks intact
            xb(8'hFF, rd, an);
        end else begin
            xb(wd, q, a2);
        end
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule // rcr_host_model

//--- dv/rcr_regs_assertions.sv
/* Port-level checker for rcr_regs, bound into every instance.
   Assumes one clock domain and decode outputs one cycle behind. */
module rcr_regs_assertions (
    input wire logic        CLK_IN,
    input wire logic        RESETN_IN,
    input wire logic        SCL_IN,
    input wire logic        SDA_OE_OUT,
    input wire logic [2:0]  FAULT_EVENT_IN,
    input wire logic [2:0]  FAULT_FLAGS_OUT,
    input wire logic [2:0]  STARTUP_DELAY_SEL_OUT,
    input wire logic [1:0]  MARGIN_SEL_OUT,
    input wire logic [1:0]  RAMP_SEL_OUT,
    input wire logic [7:0]  OUTPUT_LEVEL_CODE_OUT,
    input wire logic [12:0] LEVEL_MV_OUT,
    input wire logic [1:0]  LEVEL_RANGE_OUT,
    input wire logic [13:0] STARTUP_DELAY_US_OUT,
    input wire logic [10:0] RAMP_MV_PER_MS_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DUS [8] = '{0, 500, 1000, 2000, 4000, 6000, 8000, 10000};
    localparam int RMV [4] = '{160, 380, 760, 1500};
    function automatic int mv_of(int c);
        if (c > 244) return 4750 + 50 * (c - 245);
        if (c > 195) return 1980 + 30 * (c - 196);
        if (c > 128) return 1290 + 10 * (c - 129);
        return 640 + 5 * c;
    endfunction
    function automatic int rng_of(int c);
        return (c > 244) ? 3 : (c > 195) ? 2 : (c > 128) ? 1 : 0;
    endfunction
    default clocking dcb @(posedge CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);
    // first edge after release still shows the reset zeros, so skip it
    level_mv_a: assert property (
        $past(RESETN_IN) |->
        int'(LEVEL_MV_OUT) == mv_of($past(OUTPUT_LEVEL_CODE_OUT)))
        else $error("level mV does not match the code");
    level_range_a: assert property (
        $past(RESETN_IN) |->
        int'(LEVEL_RANGE_OUT) == rng_of($past(OUTPUT_LEVEL_CODE_OUT)))
        else $error("level range does not match the code");
    delay_map_a: assert property (
        $past(RESETN_IN) |->
        int'(STARTUP_DELAY_US_OUT) == DUS[$past(STARTUP_DELAY_SEL_OUT)])
        else $error("start-up delay does not match selector");
    ramp_map_a: assert property (
        $past(RESETN_IN) |->
        int'(RAMP_MV_PER_MS_OUT) == RMV[$past(RAMP_SEL_OUT)])
        else $error("ramp slope does not match selector");
    margin_reset_a: assert property (
        $rose(RESETN_IN) |-> MARGIN_SEL_OUT == 2'h0)
        else $error("margin not zero after reset");
    flag_set_a: assert property (
        |FAULT_EVENT_IN |=>
        (FAULT_FLAGS_OUT & $past(FAULT_EVENT_IN)) == $past(FAULT_EVENT_IN))
        else $error("fault event did not set its flag");
    flag_hold_a: assert property (
        SCL_IN |-> ($past(FAULT_FLAGS_OUT) & ~FAULT_FLAGS_OUT) == 3'h0)
        else $error("flag dropped outside a clear write");
    ack_stable_a: assert property (
        SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_OUT))
        else $error("target moved data while bus clock high");
    clear_seen_c: cover property (|FAULT_FLAGS_OUT ##1 !(|FAULT_FLAGS_OUT));
    ack_seen_c: cover property ($rose(SDA_OE_OUT));
    top_range_c: cover property (LEVEL_RANGE_OUT == 2'h3);
endmodule // rcr_regs_assertions

bind rcr_regs rcr_regs_assertions u_rcr_regs_assertions (.*);

//--- dv/testbench.sv
/* Self-checking bench for rcr_regs against an integer register model.
   Assumes the host model, checker bind and design files are compiled. */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DUS [8] = '{0, 500, 1000, 2000, 4000, 6000, 8000, 10000};
    localparam int RMV [4] = '{160, 380, 760, 1500};
    logic        clk, rst_n, scl, host_oe, sda_oe, sda_out;
    logic [2:0]  fault_ev, flags, dly_sel;
    logic [1:0]  mrg, ramp, rng;
    logic [7:0]  lvl;
    logic [12:0] mv;
    logic [13:0] dus;
    logic [10:0] rmv;
    wire         sda = !(host_oe | sda_oe);
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    int m_set, m_lvl, m_flags, m_cmd;
    rcr_regs u_rcr_regs (.CLK_IN(clk), .RESETN_IN(rst_n), .SCL_IN(scl),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe),
        .FAULT_EVENT_IN(fault_ev), .FAULT_FLAGS_OUT(flags),
        .STARTUP_DELAY_SEL_OUT(dly_sel), .MARGIN_SEL_OUT(mrg),
        .RAMP_SEL_OUT(ramp), .OUTPUT_LEVEL_CODE_OUT(lvl),
        .LEVEL_MV_OUT(mv), .LEVEL_RANGE_OUT(rng),
        .STARTUP_DELAY_US_OUT(dus), .RAMP_MV_PER_MS_OUT(rmv));
    rcr_host_model u_host (.clk_in(clk), .sda_in(sda), .scl_out(scl),
        .sda_oe_out(host_oe));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            results();
        end
    end
    function automatic int lvl_mv(int c);
        if (c > 244) return 4750 + 50 * (c - 245);
        if (c > 195) return 1980 + 30 * (c - 196);
        if (c > 128) return 1290 + 10 * (c - 129);
        return 640 + 5 * c;
    endfunction
    task automatic chk_out(input string nm, input int e,
                           input logic [15:0] g);
        n_compared++;
        if (g !== 16'(e)) begin
            error_cnt++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic chk_rd(input logic [7:0] p, input int e);
        logic [7:0] d;
        logic       ok;
        u_host.xfer(1'b1, p, 8'h00, d, ok);
        n_compared++;
        if (ok !== 1'b1 || d !== 8'(e)) begin
            error_cnt++;
            $display("BAD reg_%0h expected %0h seen %0h", p, e, d);
        end
    endtask
    task automatic wr(input logic [7:0] p, input int d);
        logic [7:0] q;
        logic       ok;
        u_host.xfer(1'b0, p, d[7:0], q, ok);
        chk_out("ack", 1, ok);
        if (p == 8'h02) m_set = d & 32'h7F;
        if (p == 8'h03) m_lvl = d & 32'hFF;
        if (p == 8'h04) m_cmd = d & 32'hFE;
        if (p == 8'h04 && d[0]) m_flags = 0;
    endtask
    task automatic chk_all();
        int r;
        r = (m_lvl > 244) ? 3 : (m_lvl > 195) ? 2 : (m_lvl > 128) ? 1 : 0;
        chk_out("delay_sel", m_set[6:4], dly_sel);
        chk_out("delay_us", DUS[m_set[6:4]], dus);
        chk_out("margin", m_set[3:2], mrg);
        chk_out("ramp", m_set[1:0], ramp);
        chk_out("ramp_mv", RMV[m_set[1:0]], rmv);
        chk_out("level", m_lvl, lvl);
        chk_out("level_mv", lvl_mv(m_lvl), mv);
        chk_out("range", r, rng);
        chk_out("flags", m_flags, flags);
        chk_out("sda_drive", 0, sda_out);
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        m_set = 0;
        m_lvl = 0;
        m_flags = 0;
        m_cmd = 0;
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        int v;
        int codes[$];
        rst_n = 1'b0;
        fault_ev = 3'h0;
        void'($urandom(32'h9AE84912));
        do_reset();
        chk_all();
        chk_rd(8'h02, 0);
        chk_rd(8'h04, 0);
        $display("test reset done");
        // no enable pin in this slice, settings change while idle
        for (int i = 0; i < 8; i++) begin
            v = ($urandom & 32'h80) | (i << 4) | ((i & 3) << 2) | (~i & 3);
            wr(8'h02, v);
            chk_all();
            chk_rd(8'h02, m_set);
        end
        $display("test settings done");
        // range end points, written as if delivery were off
        codes = '{8'h00, 8'h80, 8'h81, 8'hC3, 8'hC4, 8'hF4, 8'hF5, 8'hFF};
        codes.push_front($urandom_range(255));
        foreach (codes[k]) begin
            wr(8'h03, codes[k]);
            chk_all();
            chk_rd(8'h03, m_lvl);
        end
        // live changes: one-code steps inside the second range
        v = 8'h81 + $urandom_range(60);
        wr(8'h03, v);
        repeat (3) begin
            v++;
            wr(8'h03, v);
            chk_all();
        end
        $display("test levels done");
        fault_ev = 3'($urandom_range(7, 1));
        m_flags = fault_ev;
        @(negedge clk);
        fault_ev = 3'h0;
        chk_all();
        chk_rd(8'h00, m_flags << 5);
        wr(8'h04, 8'hFE);
        chk_all();
        chk_rd(8'h04, m_cmd);
        wr(8'h04, 8'h01);
        chk_all();
        chk_rd(8'h04, m_cmd);
        wr(8'h05, 8'h5A);
        chk_rd(8'h05, 0);
        $display("test faults done");
        do_reset();
        chk_all();
        chk_rd(8'h03, 0);
        $display("test power cycle done");
        results();
    end
endmodule // testbench

//--- rtl/rcr_level_map.sv
/*
 * Decodes the level code and settings into millivolts, range index,
 * start-up delay in us and ramp slope in mV/ms; results are registered.
 * Assumes one clock and the asynchronous active-low reset of the top.
 */
`include "rcr_map.svh"

module rcr_level_map
    import rcr_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          resetn_in,
    input  wire logic [7:0]    code_in,
    input  wire rcr_settings_s settings_in,
    output rcr_decode_s        decode_out
);
    rcr_decode_s dec_d;
    rcr_decode_s dec_q;
    logic [7:0]  off;

    always_comb begin
        off = 8'h00;
        dec_d = '0;
        if (code_in >= `RCR_R3_FIRST) begin
            // R12 top range
            off = code_in - `RCR_R3_FIRST;
            dec_d.level_range = 2'h3;
            dec_d.level_mv = `RCR_R3_BASE_MV + 13'(off) * `RCR_R3_STEP_MV;
        end else if (code_in >= `RCR_R2_FIRST) begin
            // R11 third range
            off = code_in - `RCR_R2_FIRST;
            dec_d.level_range = 2'h2;
            dec_d.level_mv = `RCR_R2_BASE_MV + 13'(off) * `RCR_R2_STEP_MV;
        end else if (code_in >= `RCR_R1_FIRST) begin
            // R10 second range
            off = code_in - `RCR_R1_FIRST;
            dec_d.level_range = 2'h1;
            dec_d.level_mv = `RCR_R1_BASE_MV + 13'(off) * `RCR_R1_STEP_MV;
        end else begin
            // R9 fine range
            off = code_in;
            dec_d.level_range = 2'h0;
            dec_d.level_mv = `RCR_R0_BASE_MV + 13'(off) * `RCR_R0_STEP_MV;
        end
        // R2 start-up delay table
        case (settings_in.delay_sel)
            3'h0:    dec_d.delay_us = `RCR_DLY0_US;
            3'h1:    dec_d.delay_us = `RCR_DLY1_US;
            3'h2:    dec_d.delay_us = `RCR_DLY2_US;
            3'h3:    dec_d.delay_us = `RCR_DLY3_US;
            3'h4:    dec_d.delay_us = `RCR_DLY4_US;
            3'h5:    dec_d.delay_us = `RCR_DLY5_US;
            3'h6:    dec_d.delay_us = `RCR_DLY6_US;
            default: dec_d.delay_us = `RCR_DLY7_US;
        endcase
        // R5 ramp slope table
        case (settings_in.ramp_sel)
            2'h0:    dec_d.ramp_mv_ms = `RCR_RAMP0_MVMS;
            2'h1:    dec_d.ramp_mv_ms = `RCR_RAMP1_MVMS;
            2'h2:    dec_d.ramp_mv_ms = `RCR_RAMP2_MVMS;
            default: dec_d.ramp_mv_ms = `RCR_RAMP3_MVMS;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dec_q <= '0;
        end else begin
            dec_q <= dec_d;
        end
    end

    assign decode_out = dec_q;
endmodule // rcr_level_map

//--- rtl/rcr_map.svh
/*
 * Register offsets, field positions, reset values and level-map constants
 * of the regulator configuration register slice.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH

// byte addresses selected by the serial pointer byte
`define RCR_OFS_STATUS    8'h00
`define RCR_OFS_SETTINGS  8'h02
`define RCR_OFS_LEVEL     8'h03
`define RCR_OFS_COMMAND   8'h04

// second settings register fields and command clear bit
`define RCR_DLY_MSB       6
`define RCR_DLY_LSB       4
`define RCR_MRG_MSB       3
`define RCR_MRG_LSB       2
`define RCR_RAMP_MSB      1
`define RCR_RAMP_LSB      0
`define RCR_CLR_BIT       0

// reset values and default device address
`define RCR_DEF_SETTINGS  8'h00
`define RCR_DEF_LEVEL     8'h00
`define RCR_MRG_RESET     2'h0
`define RCR_CMD_RESET     8'h00
`define RCR_DEV_ADDR      7'h50

// output level ranges: first code, base in mV, step in mV
`define RCR_R1_FIRST      8'h81
`define RCR_R2_FIRST      8'hC4
`define RCR_R3_FIRST      8'hF5
`define RCR_R0_BASE_MV    13'h0280
`define RCR_R0_STEP_MV    13'h0005
`define RCR_R1_BASE_MV    13'h050A
`define RCR_R1_STEP_MV    13'h000A
`define RCR_R2_BASE_MV    13'h07BC
`define RCR_R2_STEP_MV    13'h001E
`define RCR_R3_BASE_MV    13'h128E
`define RCR_R3_STEP_MV    13'h0032

// start-up delays in us for codes 0..7
`define RCR_DLY0_US       14'h0000
`define RCR_DLY1_US       14'h01F4
`define RCR_DLY2_US       14'h03E8
`define RCR_DLY3_US       14'h07D0
`define RCR_DLY4_US       14'h0FA0
`define RCR_DLY5_US       14'h1770
`define RCR_DLY6_US       14'h1F40
`define RCR_DLY7_US       14'h2710

// soft-start slopes in mV/ms for codes 0..3
`define RCR_RAMP0_MVMS    11'h0A0
`define RCR_RAMP1_MVMS    11'h17C
`define RCR_RAMP2_MVMS    11'h2F8
`define RCR_RAMP3_MVMS    11'h5DC

`endif

//--- rtl/rcr_pkg.sv
/*
 * Types of the regulator configuration register slice.
 * Assumes rcr_map.svh is on the include path.
 */
package rcr_pkg;
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_AACK = 9'h004,
        ST_PTR  = 9'h008,
        ST_PACK = 9'h010,
        ST_WDAT = 9'h020,
        ST_WACK = 9'h040,
        ST_RDAT = 9'h080,
        ST_RACK = 9'h100
    } rcr_state_e;

    typedef struct packed {
        logic [2:0] delay_sel;
        logic [1:0] margin_sel;
        logic [1:0] ramp_sel;
    } rcr_settings_s;

    typedef struct packed {
        logic [12:0] level_mv;
        logic [1:0]  level_range;
        logic [13:0] delay_us;
        logic [10:0] ramp_mv_ms;
    } rcr_decode_s;
endpackage

//--- rtl/rcr_regs.sv
/*
 * Serial-target register slice of a programmable buck regulator:
 * pointer-addressed byte reads and writes, second settings register,
 * output level code, command register and latched fault flags.
 * Assumes SCL and SDA already synchronous to CLK_IN, which runs well
 * above the bus bit rate; SDA is open drain, resolved outside.
 */
`include "rcr_map.svh"

// Behaviour
// R1 - settings bit 7 reads zero; writes to it are dropped.
// R2 - settings bits 6:4 select start-up delay 0 to 10 ms.
// R3 - settings bits 3:2 select margin: none, -5%, +5%, +5%.
// R4 - margin selector resets to zero whatever the factory defaults.
// R5 - settings bits 1:0 select ramp slope 0.16 to 1.5 V/ms.
// R6 - host should disable, write settings, re-enable; margin excepted.
// R7 - host changes live level code only in small steps.
// R8 - host keeps live level changes inside one resolution range.
// R9 - codes 0..128 give 0.640 V upward in 5 mV steps.
// R10 - codes 129..195 give 1.290 V upward in 10 mV steps.
// R11 - codes 196..244 give 1.980 V upward in 30 mV steps.
// R12 - codes 245..255 give 4.750 V upward in 50 mV steps.
// R13 - serial writes are volatile; reset reloads factory defaults.
// R14 - command bits 7:1 store writes but steer nothing.
// R15 - writing one to command bit 0 clears all fault flags.
// R16 - the clear bit drops to zero once flags are cleared.
// R17 - fault flags stay set until clear command or power cycle.
// R18 - serial target; pointer byte selects register; byte reads, writes.
module rcr_regs
    import rcr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR     = `RCR_DEV_ADDR,
    parameter logic [7:0] DEF_SETTINGS = `RCR_DEF_SETTINGS,
    parameter logic [7:0] DEF_LEVEL    = `RCR_DEF_LEVEL
) (
    input  wire logic        CLK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_OUT,
    input  wire logic [2:0]  FAULT_EVENT_IN,
    output logic      [2:0]  FAULT_FLAGS_OUT,
    output logic      [2:0]  STARTUP_DELAY_SEL_OUT,
    output logic      [1:0]  MARGIN_SEL_OUT,
    output logic      [1:0]  RAMP_SEL_OUT,
    output logic      [7:0]  OUTPUT_LEVEL_CODE_OUT,
    output logic      [12:0] LEVEL_MV_OUT,
    output logic      [1:0]  LEVEL_RANGE_OUT,
    output logic      [13:0] STARTUP_DELAY_US_OUT,
    output logic      [10:0] RAMP_MV_PER_MS_OUT
);
    rcr_state_e    state_q, state_d;
    logic [3:0]    cnt_q, cnt_d;
    logic [7:0]    sh_q, sh_d;
    logic [7:0]    ptr_q, ptr_d;
    logic          rw_q, rw_d;
    logic          nack_q, nack_d;
    logic          oe_q, oe_d;
    logic          scl_q, sda_q;
    logic          wr_en;
    logic          scl_rise, scl_fall, start_c, stop_c;

    rcr_settings_s set_q, set_d;
    logic [7:0]    level_q, level_d;
    logic [6:0]    cmd_hi_q, cmd_hi_d;
    logic          clr_q, clr_d;
    logic [2:0]    flags_q, flags_d;
    rcr_decode_s   decode;

    // R1 unimplemented bit and unmapped offsets read zero
    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        case (a)
            `RCR_OFS_STATUS:   rd_byte = {flags_q, 5'h00};
            `RCR_OFS_SETTINGS: rd_byte = {1'b0, set_q};
            `RCR_OFS_LEVEL:    rd_byte = level_q;
            `RCR_OFS_COMMAND:  rd_byte = {cmd_hi_q, clr_q};
            default:           rd_byte = 8'h00;
        endcase
    endfunction

    assign scl_rise = SCL_IN & ~scl_q;
    assign scl_fall = ~SCL_IN & scl_q;
    assign start_c  = SCL_IN & scl_q & sda_q & ~SDA_IN;
    assign stop_c   = SCL_IN & scl_q & ~sda_q & SDA_IN;

    // R18 byte-level target sequencing
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        ptr_d   = ptr_q;
        rw_d    = rw_q;
        nack_d  = nack_q;
        oe_d    = oe_q;
        wr_en   = 1'b0;
        if (start_c) begin
            state_d = ST_ADDR;
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
        end else if (stop_c) begin
            state_d = ST_IDLE;
            oe_d    = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WDAT: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], SDA_IN};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        oe_d = 1'b1;
                        if (state_q == ST_ADDR) begin
                            rw_d = sh_q[0];
                            if (sh_q[7:1] == DEV_ADDR) begin
                                state_d = ST_AACK;
                            end else begin
                                state_d = ST_IDLE;
                                oe_d    = 1'b0;
                            end
                        end else if (state_q == ST_PTR) begin
                            ptr_d   = sh_q;
                            state_d = ST_PACK;
                        end else begin
                            wr_en   = 1'b1;
                            ptr_d   = ptr_q + 8'h01;
                            state_d = ST_WACK;
                        end
                    end
                end
                ST_AACK, ST_PACK, ST_WACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        oe_d  = 1'b0;
                        if (state_q != ST_AACK) begin
                            state_d = ST_WDAT;
                        end else if (rw_q) begin
                            // R18 read begins at the held pointer
                            sh_d    = rd_byte(ptr_q);
                            oe_d    = ~sh_d[7];
                            ptr_d   = ptr_q + 8'h01;
                            state_d = ST_RDAT;
                        end else begin
                            state_d = ST_PTR;
                        end
                    end
                end
                ST_RDAT: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == 4'h8) begin
                            oe_d    = 1'b0;
                            state_d = ST_RACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        nack_d = SDA_IN;
                    end else if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (nack_q) begin
                            state_d = ST_IDLE;
                        end else begin
                            sh_d    = rd_byte(ptr_q);
                            oe_d    = ~sh_d[7];
                            ptr_d   = ptr_q + 8'h01;
                            state_d = ST_RDAT;
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            ptr_q   <= 8'h00;
            rw_q    <= 1'b0;
            nack_q  <= 1'b0;
            oe_q    <= 1'b0;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            ptr_q   <= ptr_d;
            rw_q    <= rw_d;
            nack_q  <= nack_d;
            oe_q    <= oe_d;
            scl_q   <= SCL_IN;
            sda_q   <= SDA_IN;
        end
    end

    always_comb begin
        set_d    = set_q;
        level_d  = level_q;
        cmd_hi_d = cmd_hi_q;
        // R16 self-clearing on the same edge that wipes the flags
        clr_d    = 1'b0;
        // R17 flags latch; a new event wins over the clear
        flags_d  = (clr_q ? 3'h0 : flags_q) | FAULT_EVENT_IN;
        if (wr_en) begin
            case (ptr_q)
                `RCR_OFS_SETTINGS: begin
                    // R1 bit 7 is not stored
                    // R2 R3 R5 fields take the written byte
                    set_d = sh_q[6:0];
                end
                // R7 level code accepted at any time
                `RCR_OFS_LEVEL: level_d = sh_q;
                `RCR_OFS_COMMAND: begin
                    // R14 upper bits stored only
                    cmd_hi_d = sh_q[7:1];
                    // R15 request the flag clear
                    clr_d    = sh_q[`RCR_CLR_BIT];
                end
                default: ;
            endcase
        end
    end

    // R13 factory defaults reload at every reset
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            set_q            <= DEF_SETTINGS[6:0];
            // R4 margin forced to zero at power-up
            set_q.margin_sel <= `RCR_MRG_RESET;
            level_q          <= DEF_LEVEL;
            cmd_hi_q         <= 7'(`RCR_CMD_RESET >> 1);
            clr_q            <= 1'b0;
            flags_q          <= 3'h0;
        end else begin
            set_q    <= set_d;
            level_q  <= level_d;
            cmd_hi_q <= cmd_hi_d;
            clr_q    <= clr_d;
            flags_q  <= flags_d;
        end
    end

    // R9 R10 R11 R12 level code to millivolts
    rcr_level_map u_map (
        .clk_in      (CLK_IN),
        .resetn_in   (RESETN_IN),
        .code_in     (level_q),
        .settings_in (set_q),
        .decode_out  (decode)
    );

    // open drain: the pad only ever pulls low
    assign SDA_OUT               = 1'b0;
    assign SDA_OE_OUT            = oe_q;
    assign FAULT_FLAGS_OUT       = flags_q;
    assign STARTUP_DELAY_SEL_OUT = set_q.delay_sel;
    // R3 margin may change during delivery, passed straight out
    assign MARGIN_SEL_OUT        = set_q.margin_sel;
    assign RAMP_SEL_OUT          = set_q.ramp_sel;
    assign OUTPUT_LEVEL_CODE_OUT = level_q;
    assign LEVEL_MV_OUT          = decode.level_mv;
    assign LEVEL_RANGE_OUT       = decode.level_range;
    assign STARTUP_DELAY_US_OUT  = decode.delay_us;
    assign RAMP_MV_PER_MS_OUT    = decode.ramp_mv_ms;
endmodule // rcr_regs
